// File: common/qcm_consts.vh
// register offsets, field positions, reset values and sizes for the class and queue mapper
`ifndef QCM_CONSTS_VH
`define QCM_CONSTS_VH

// register byte offsets
`define QCM_OFF_CTRL      12'h000
`define QCM_OFF_PRIMAP    12'h004
`define QCM_OFF_COSQ      12'h008
`define QCM_OFF_PORTSET   12'h00C
`define QCM_OFF_VLANCMD   12'h010
`define QCM_OFF_MACLO     12'h014
`define QCM_OFF_MACCMD    12'h018
`define QCM_OFF_WEIGHTS   12'h01C
`define QCM_OFF_STATUS    12'h020
`define QCM_OFF_LASTCLS   12'h024

// control fields
`define QCM_CTRL_STRICT   0
`define QCM_CTRL_PDEF_LO  4
`define QCM_CTRL_PDEF_HI  6

// table command fields
`define QCM_CMD_COS_LO    16
`define QCM_CMD_COS_HI    18
`define QCM_CMD_DEL       24
`define QCM_CMD_SLOT_LO   28
`define QCM_CMD_SLOT_HI   31
`define QCM_PORT_COS_LO   24
`define QCM_PORT_COS_HI   26

// vlan id range and table sizes
`define QCM_VID_MIN       12'h001
`define QCM_VID_MAX       12'h82E
`define QCM_VLAN_SLOTS    16
`define QCM_MAC_SLOTS     16
`define QCM_PORTS         24

// reset values and the read data of unmapped addresses
`define QCM_PRIMAP_RST    24'hFAC688
`define QCM_COSQ_RST      16'hFA50
`define QCM_WEIGHTS_RST   32'h01020408
`define QCM_SLVERR_DATA   32'hDEADBEEF

`endif

// File: design/qcm_cam.v
// small associative table: key to class, with add, overwrite and delete by slot
`timescale 1ns/1ps
`default_nettype none
module qcm_cam #(
  parameter KEYW  = 12,
  parameter SLOTS = 16,
  parameter SLOTW = 4
) (
  // clock and reset
  input  wire             sys_clk,
  input  wire             reset_n,
  // programming
  input  wire             wrEn,
  input  wire             wrDel,
  input  wire [SLOTW-1:0] wrSlot,
  input  wire [KEYW-1:0]  wrKey,
  input  wire [2:0]       wrCos,
  // lookup
  input  wire [KEYW-1:0]  lookKey,
  output reg              lookHit,
  output reg  [2:0]       lookCos,
  output wire [SLOTS-1:0] validMap
);
  wire [SLOTS-1:0]   match;
  wire [3*SLOTS-1:0] cosVec;
  integer            k;

  genvar g;
  generate
    for (g = 0; g < SLOTS; g = g + 1) begin : gSlot
      // each entry owns its storage, so no variable is written from two processes
      reg [KEYW-1:0] key_q;
      reg [2:0]      cos_q;
      reg            valid_q;
      // one entry: delete clears valid so the key no longer matches
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          key_q   <= {KEYW{1'b0}};
          cos_q   <= 3'h0;
          valid_q <= 1'b0;
        end else if (wrEn && wrSlot == g) begin
          key_q   <= wrKey;
          cos_q   <= wrCos;
          valid_q <= ~wrDel;
        end
      end
      assign match[g]         = valid_q && (key_q == lookKey);
      assign validMap[g]      = valid_q;
      assign cosVec[3*g +: 3] = cos_q;
    end
  endgenerate

  // lowest matching slot wins; software keeps keys unique
  always @* begin
    lookHit = 1'b0;
    lookCos = 3'h0;
    for (k = SLOTS - 1; k >= 0; k = k - 1) begin
      if (match[k]) begin
        lookHit = 1'b1;
        lookCos = cosVec[3*k +: 3];
      end
    end
  end
endmodule // qcm_cam
`default_nettype wire

// File: design/qcm_sched.v
// egress queue scheduler: strict priority or weighted round robin over four queues
`timescale 1ns/1ps
`default_nettype none
module qcm_sched (
  // clock and reset
  input  wire        sys_clk,
  input  wire        reset_n,
  // policy
  input  wire        strictMode,
  input  wire [31:0] weights,
  // queues
  input  wire [3:0]  queueReq,
  input  wire        grantTaken,
  output reg  [1:0]  grantQueue,
  output reg         grantValid
);
  reg [1:0] cur_q;
  reg [1:0] cur_d;
  reg [7:0] credit_q;
  reg [7:0] credit_d;
  reg [1:0] pick;
  reg       found;
  integer   i;

  // strict picks highest queue; wrr stays on current queue while credit lasts
  always @* begin
    pick  = 2'h0;
    found = 1'b0;
    if (strictMode) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (queueReq[i]) begin
          pick  = i[1:0];
          found = 1'b1;
        end
      end
    end else if (queueReq[cur_q] && credit_q != 8'h00) begin
      pick  = cur_q;
      found = 1'b1;
    end else begin
      for (i = 4; i >= 1; i = i - 1) begin
        if (queueReq[(cur_q - i[1:0]) & 2'h3]) begin
          pick  = cur_q - i[1:0];
          found = 1'b1;
        end
      end
    end
    grantQueue = pick;
    grantValid = found;
  end

  // credit reload when the grant moves to another queue
  always @* begin
    cur_d    = cur_q;
    credit_d = credit_q;
    if (grantValid && grantTaken && !strictMode) begin
      if (pick != cur_q || credit_q == 8'h00) begin
        cur_d    = pick;
        credit_d = weights[pick*8 +: 8] - 8'h01;
      end else begin
        credit_d = credit_q - 8'h01;
      end
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_q    <= 2'h0;
      credit_q <= 8'h00;
    end else begin
      cur_q    <= cur_d;
      credit_q <= credit_d;
    end
  end
endmodule // qcm_sched
`default_nettype wire

// File: design/qcm_mapper.v
// class-of-service classifier and egress queue mapper with apb registers
// Behaviour
// - a writable table gives a class 0..7 to vlan ids 1 through 2094.
// - the eight priority levels of a frame's priority tag feed classification.
// - a writable map turns each tagged level 0..7 into a class 0..7.
// - one write gives a set of ingress ports a shared class 0..7.
// - a writable map sends each class 0..7 to egress queue 0..3.
// - queues are served by weighted round robin or strict priority, as selected.
// - a vlan table entry can be deleted and then no longer classifies.
// - class 7 is highest and class 0 lowest.
// - four sources (tag, port, mac, vlan) feed four queues.
// - a writable table gives a class to a mac address.
`timescale 1ns/1ps
`default_nettype none
`include "qcm_consts.vh"
module qcm_mapper #(
  parameter PORTS = `QCM_PORTS,
  parameter SLOTS = `QCM_VLAN_SLOTS
) (
  // clock and reset
  input  wire        sys_clk,
  input  wire        reset_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // frame descriptor from the parser
  input  wire        frmValid,
  input  wire        frmTagged,
  input  wire [2:0]  frmPri,
  input  wire [11:0] frmVid,
  input  wire [4:0]  frmPort,
  input  wire [47:0] frmMac,
  output reg         clsValid,
  output reg  [2:0]  clsCos,
  output reg  [1:0]  clsQueue,
  // egress queue arbitration
  input  wire [3:0]  queueReq,
  input  wire        grantTaken,
  output wire [1:0]  grantQueue,
  output wire        grantValid
);
  // registers
  reg [7:0]        ctrl_q;
  reg [23:0]       priMap_q;
  reg [15:0]       cosQ_q;
  reg [31:0]       weights_q;
  reg [31:0]       macLo_q;
  wire [3*PORTS-1:0] portCosMap;
  reg [15:0]       rejects_q;
  wire             wrAcc;
  wire             rdSetup;
  wire             wrCtrl;
  wire             wrPriMap;
  wire             wrCosQ;
  wire             wrPortSet;
  wire             wrVlanCmd;
  wire             wrMacLo;
  wire             wrMacCmd;
  wire             wrWeights;
  wire             cmdDel;
  wire             vlanReject;
  wire             vlanWr;
  wire             vidOk;
  wire             macWr;
  wire             vHit;
  wire [2:0]       vCos;
  wire             mHit;
  wire [2:0]       mCos;
  wire [SLOTS-1:0] vValid;
  wire [SLOTS-1:0] mValid;
  wire [2:0]       tagCos;
  wire [2:0]       portCos;
  reg  [2:0]       cos_d;
  wire             mapped;
  reg  [31:0]      rdMux;

  // single-cycle slave: access phase always completes at once
  assign pready  = 1'b1;
  assign wrAcc   = psel && penable && pwrite;
  assign rdSetup = psel && !penable && !pwrite;
  assign mapped  = (paddr[1:0] == 2'b00) && (paddr <= `QCM_OFF_LASTCLS);
  assign pslverr = psel && penable && !mapped;

  // one decoded strobe per writable register; every write needs the full access phase
  assign wrCtrl    = wrAcc && (paddr == `QCM_OFF_CTRL);
  assign wrPriMap  = wrAcc && (paddr == `QCM_OFF_PRIMAP);
  assign wrCosQ    = wrAcc && (paddr == `QCM_OFF_COSQ);
  assign wrPortSet = wrAcc && (paddr == `QCM_OFF_PORTSET);
  assign wrVlanCmd = wrAcc && (paddr == `QCM_OFF_VLANCMD);
  assign wrMacLo   = wrAcc && (paddr == `QCM_OFF_MACLO);
  assign wrMacCmd  = wrAcc && (paddr == `QCM_OFF_MACCMD);
  assign wrWeights = wrAcc && (paddr == `QCM_OFF_WEIGHTS);
  assign cmdDel    = pwdata[`QCM_CMD_DEL];

  // vid outside 1..2094 is refused and counted; a delete needs no valid vid
  assign vidOk      = (pwdata[11:0] >= `QCM_VID_MIN) && (pwdata[11:0] <= `QCM_VID_MAX);
  assign vlanWr     = wrVlanCmd && (vidOk || cmdDel);
  assign vlanReject = wrVlanCmd && !vidOk && !cmdDel;
  assign macWr      = wrMacCmd;

  // queue policy and the class for ports beyond the port count
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      ctrl_q <= 8'h00;
    else if (wrCtrl)
      ctrl_q <= pwdata[7:0];
  end

  // tagged priority to class map, identity after reset
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      priMap_q <= `QCM_PRIMAP_RST;
    else if (wrPriMap)
      priMap_q <= pwdata[23:0];
  end

  // class to queue map; the reset map keeps class 7 on the top queue
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      cosQ_q <= `QCM_COSQ_RST;
    else if (wrCosQ)
      cosQ_q <= pwdata[15:0];
  end

  // round robin weights, one byte per queue; zero gives a full 256-grant turn
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      weights_q <= `QCM_WEIGHTS_RST;
    else if (wrWeights)
      weights_q <= pwdata;
  end

  // low mac word waits here until the command write brings the high part
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      macLo_q <= 32'h00000000;
    else if (wrMacLo)
      macLo_q <= pwdata;
  end

  // counter saturates rather than wrapping, so a flood stays visible
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      rejects_q <= 16'h0000;
    else if (vlanReject && rejects_q != 16'hFFFF)
      rejects_q <= rejects_q + 16'h0001;
  end

  // port class: one write loads every port whose bit is set in the port mask
  genvar p;
  generate
    for (p = 0; p < PORTS; p = p + 1) begin : gPort
      reg [2:0] cos_q;
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
          cos_q <= 3'h0;
        else if (wrPortSet && pwdata[p])
          cos_q <= pwdata[`QCM_PORT_COS_HI:`QCM_PORT_COS_LO];
      end
      assign portCosMap[3*p +: 3] = cos_q;
    end
  endgenerate

  // vlan to class table
  qcm_cam #(.KEYW(12), .SLOTS(SLOTS), .SLOTW(4)) uVlan (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .wrEn     (vlanWr),
    .wrDel    (pwdata[`QCM_CMD_DEL]),
    .wrSlot   (pwdata[`QCM_CMD_SLOT_HI:`QCM_CMD_SLOT_LO]),
    .wrKey    (pwdata[11:0]),
    .wrCos    (pwdata[`QCM_CMD_COS_HI:`QCM_CMD_COS_LO]),
    .lookKey  (frmVid),
    .lookHit  (vHit),
    .lookCos  (vCos),
    .validMap (vValid)
  );

  // mac to class table; upper 16 address bits travel with the command
  qcm_cam #(.KEYW(48), .SLOTS(SLOTS), .SLOTW(4)) uMac (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .wrEn     (macWr),
    .wrDel    (pwdata[`QCM_CMD_DEL]),
    .wrSlot   (pwdata[`QCM_CMD_SLOT_HI:`QCM_CMD_SLOT_LO]),
    .wrKey    ({pwdata[15:0], macLo_q}),
    .wrCos    (pwdata[`QCM_CMD_COS_HI:`QCM_CMD_COS_LO]),
    .lookKey  (frmMac),
    .lookHit  (mHit),
    .lookCos  (mCos),
    .validMap (mValid)
  );

  assign tagCos  = priMap_q[3*frmPri +: 3];
  assign portCos = (frmPort < PORTS) ? portCosMap[3*frmPort +: 3]
                                     : ctrl_q[`QCM_CTRL_PDEF_HI:`QCM_CTRL_PDEF_LO];

  // source precedence among the four classifiers
  always @* begin
    if (mHit)
      cos_d = mCos;
    else if (vHit)
      cos_d = vCos;
    else if (frmTagged)
      cos_d = tagCos;
    else
      cos_d = portCos;
  end

  // registered classification result, one cycle after the descriptor
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      clsValid <= 1'b0;
      clsCos   <= 3'h0;
      clsQueue <= 2'h0;
    end else begin
      clsValid <= frmValid;
      if (frmValid) begin
        clsCos   <= cos_d;
        clsQueue <= cosQ_q[2*cos_d +: 2];
      end
    end
  end

  // queue 3 is the highest; default cos map keeps class 7 on it
  qcm_sched uSched (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .strictMode (ctrl_q[`QCM_CTRL_STRICT]),
    .weights    (weights_q),
    .queueReq   (queueReq),
    .grantTaken (grantTaken),
    .grantQueue (grantQueue),
    .grantValid (grantValid)
  );

  // read mux, looked up while the setup cycle stands
  always @* begin
    rdMux = 32'h00000000;
    case (paddr)
      `QCM_OFF_CTRL:    rdMux = {24'h000000, ctrl_q};
      `QCM_OFF_PRIMAP:  rdMux = {8'h00, priMap_q};
      `QCM_OFF_COSQ:    rdMux = {16'h0000, cosQ_q};
      `QCM_OFF_MACLO:   rdMux = macLo_q;
      `QCM_OFF_WEIGHTS: rdMux = weights_q;
      `QCM_OFF_STATUS:  rdMux = {mValid, vValid};
      `QCM_OFF_LASTCLS: rdMux = {rejects_q, 11'h000, clsQueue, clsCos};
      `QCM_OFF_PORTSET: rdMux = 32'h00000000;
      `QCM_OFF_VLANCMD: rdMux = 32'h00000000;
      `QCM_OFF_MACCMD:  rdMux = 32'h00000000;
      default:          rdMux = `QCM_SLVERR_DATA;
    endcase
  end

  // read data is captured as the setup cycle ends, so the access cycle shows a flop
  // output with no wait state; a value that changes on that very edge is seen old
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      prdata <= 32'h00000000;
    else if (rdSetup)
      prdata <= rdMux;
    else
      prdata <= 32'h00000000;
  end
endmodule // qcm_mapper
`default_nettype wire

// File: dv/qcm_checker.sv
// port assertions for the class and queue mapper
`timescale 1ns/1ps
`default_nettype none
`include "qcm_consts.vh"
module qcm_checker (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        reset_n,
  // register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // frames and queues
  input wire logic        frmValid,
  input wire logic        clsValid,
  input wire logic [2:0]  clsCos,
  input wire logic [1:0]  clsQueue,
  input wire logic [3:0]  queueReq,
  input wire logic [1:0]  grantQueue,
  input wire logic        grantValid
);
  logic        strictMode_q;
  logic [15:0] queueMap_q;
  wire         wrAcc = psel && penable && pwrite && pready;
  // shadow of policy and queue map, so outputs can be judged without peeking inside
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      strictMode_q <= 1'h0;
      queueMap_q   <= `QCM_COSQ_RST;
    end else if (wrAcc) begin
      if (paddr == `QCM_OFF_CTRL) strictMode_q <= pwdata[0];
      if (paddr == `QCM_OFF_COSQ) queueMap_q <= pwdata[15:0];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  cls_answer_a: assert property (frmValid |=> clsValid)
    else $error("class result missing after frame");
  cls_single_a: assert property (!frmValid |=> !clsValid)
    else $error("class result without frame");
  cls_hold_a: assert property (clsValid && !frmValid |=> $stable(clsCos) && $stable(clsQueue))
    else $error("class result changed without frame");
  queue_map_a: assert property (clsValid |-> clsQueue == queueMap_q[2*clsCos +: 2])
    else $error("queue does not follow class map");
  grant_any_a: assert property (grantValid == (queueReq != 4'h0))
    else $error("grant valid does not track requests");
  grant_legal_a: assert property (grantValid |-> queueReq[grantQueue])
    else $error("grant to empty queue");
  strict_top_a: assert property (strictMode_q && grantValid |-> (queueReq >> grantQueue) == 4'h1)
    else $error("strict mode skipped a higher queue");
  bad_addr_a: assert property (psel && penable && (paddr > `QCM_OFF_LASTCLS || paddr[1:0] != 2'h0)
    |-> pslverr && (pwrite || prdata == `QCM_SLVERR_DATA))
    else $error("unmapped access not refused");
  good_addr_a: assert property (psel && penable && paddr <= `QCM_OFF_LASTCLS && paddr[1:0] == 2'h0
    |-> pready && !pslverr)
    else $error("mapped access refused or stalled");
endmodule // qcm_checker
bind qcm_mapper qcm_checker u_chk (
  .sys_clk    (sys_clk),
  .reset_n    (reset_n),
  .psel       (psel),
  .penable    (penable),
  .pwrite     (pwrite),
  .paddr      (paddr),
  .pwdata     (pwdata),
  .pready     (pready),
  .prdata     (prdata),
  .pslverr    (pslverr),
  .frmValid   (frmValid),
  .clsValid   (clsValid),
  .clsCos     (clsCos),
  .clsQueue   (clsQueue),
  .queueReq   (queueReq),
  .grantQueue (grantQueue),
  .grantValid (grantValid)
);
`default_nettype wire

// File: dv/qcm_egress_model.sv
// egress queue model: per-queue frame counts that drain on taken grants
`timescale 1ns/1ps
`default_nettype none
module qcm_egress_model (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // bench control
  input  wire logic        loadEn,
  input  wire logic [15:0] loadCnt,
  // scheduler side
  input  wire logic [1:0]  grantQueue,
  input  wire logic        grantValid,
  output logic      [3:0]  queueReq,
  output logic             grantTaken
);
  logic [3:0] cnt_q [4];
  // a queue asks while it holds frames; every grant is taken at once
  always_comb begin
    for (int i = 0; i < 4; i++) queueReq[i] = cnt_q[i] != 4'h0;
    grantTaken = grantValid;
  end
  // one frame leaves the granted queue per taken grant
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) cnt_q <= '{default: 4'h0};
    else if (loadEn) for (int i = 0; i < 4; i++) cnt_q[i] <= loadCnt[4*i +: 4];
    else if (grantTaken) cnt_q[grantQueue] <= cnt_q[grantQueue] - 4'h1;
  end
endmodule // qcm_egress_model
`default_nettype wire

// File: dv/qcm_mapper_test.sv
// self-checking bench for the class and queue mapper
`timescale 1ns/1ps
`default_nettype none
`include "qcm_consts.vh"
module qcm_mapper_test;
  logic        sys_clk = 1'h0, reset_n = 1'h0, pready, pslverr, err;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, loadEn = 1'h0;
  logic [11:0] paddr = 12'h0, frmVid = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        frmValid = 1'h0, frmTagged = 1'h0, clsValid, grantTaken, grantValid;
  logic [2:0]  frmPri = 3'h0, clsCos;
  logic [4:0]  frmPort = 5'h0;
  logic [47:0] frmMac = 48'h0;
  logic [1:0]  clsQueue, grantQueue;
  logic [3:0]  queueReq;
  logic [15:0] loadCnt = 16'h0;
  int          n_mismatch = 0, checked = 0;
  qcm_mapper DUT (.sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .frmValid, .frmTagged, .frmPri, .frmVid, .frmPort, .frmMac, .clsValid,
    .clsCos, .clsQueue, .queueReq, .grantTaken, .grantQueue, .grantValid);
  qcm_egress_model u_egress (.sys_clk, .reset_n, .loadEn, .loadCnt, .grantQueue, .grantValid,
    .queueReq, .grantTaken);
  always #50 sys_clk = ~sys_clk;
  task automatic chk(input string what, input logic [31:0] exp, seen);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one transfer: setup, access held until ready, then release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    @(posedge sys_clk);
    // no wait-state count is assumed; only the watchdog ends a stalled access
    while (pready !== 1'h1)
      @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // one descriptor; result is looked at in the cycle it stands
  task automatic frm(input logic t, input logic [2:0] p, input logic [11:0] v,
                     input logic [4:0] pt);
    @(posedge sys_clk);
    frmValid <= 1'h1;
    frmTagged <= t;
    frmPri <= p;
    frmVid <= v;
    frmPort <= pt;
    @(posedge sys_clk);
    frmValid <= 1'h0;
    #1;
  endtask
  task automatic t_prio;
    logic [31:0] m;
    logic [15:0] q;
    m = 32'h0;
    q = `QCM_COSQ_RST;
    apb(1'h0, `QCM_OFF_PRIMAP, 32'h0);
    chk("primap", `QCM_PRIMAP_RST, rd);
    apb(1'h0, 12'h040, 32'h0);
    chk("slverr", 32'h1, err);
    chk("slverrData", `QCM_SLVERR_DATA, rd);
    apb(1'h0, `QCM_OFF_WEIGHTS, 32'h0);
    chk("weights", `QCM_WEIGHTS_RST, rd);
    for (int n = 0; n < 8; n++) m[3*n +: 3] = 3'(7 - n);
    apb(1'h1, `QCM_OFF_PRIMAP, m);
    for (int n = 0; n < 8; n++) begin
      frm(1'h1, 3'(n), 12'h0, 5'h0);
      chk("clsCos", 7 - n, clsCos);
      chk("clsQueue", q[2*(7-n) +: 2], clsQueue);
    end
    apb(1'h1, `QCM_OFF_COSQ, 32'h05AF);
    frm(1'h1, 3'h0, 12'h0, 5'h0);
    chk("clsQueue", 32'h0, clsQueue);
    $display("test priority map done");
  endtask
  task automatic t_vlan;
    apb(1'h1, `QCM_OFF_VLANCMD, 32'h0005082E);
    apb(1'h1, `QCM_OFF_VLANCMD, 32'h10020001);
    apb(1'h1, `QCM_OFF_VLANCMD, 32'h2003082F);
    apb(1'h1, `QCM_OFF_VLANCMD, 32'h30030000);
    frm(1'h1, 3'h0, 12'h82E, 5'h0);
    chk("clsCos", 32'h5, clsCos);
    frm(1'h1, 3'h0, 12'h001, 5'h0);
    chk("clsCos", 32'h2, clsCos);
    frm(1'h1, 3'h0, 12'h82F, 5'h0);
    chk("clsCos", 32'h7, clsCos);
    apb(1'h0, `QCM_OFF_LASTCLS, 32'h0);
    chk("rejects", 32'h2, rd[31:16]);
    apb(1'h1, `QCM_OFF_VLANCMD, 32'h01000000);
    apb(1'h0, `QCM_OFF_STATUS, 32'h0);
    chk("vlanValid", 32'h2, rd[15:0]);
    frm(1'h1, 3'h0, 12'h82E, 5'h0);
    chk("clsCos", 32'h7, clsCos);
    $display("test vlan table done");
  endtask
  task automatic t_port;
    apb(1'h1, `QCM_OFF_PORTSET, 32'h0600008E);
    frm(1'h0, 3'h0, 12'h0, 5'h02);
    chk("clsCos", 32'h6, clsCos);
    frm(1'h0, 3'h0, 12'h0, 5'h07);
    chk("clsCos", 32'h6, clsCos);
    frm(1'h0, 3'h0, 12'h0, 5'h04);
    chk("clsCos", 32'h0, clsCos);
    frm(1'h1, 3'h3, 12'h0, 5'h03);
    chk("clsCos", 32'h4, clsCos);
    apb(1'h1, `QCM_OFF_CTRL, 32'h00000050);
    frm(1'h0, 3'h0, 12'h0, 5'h18);
    chk("clsCos", 32'h5, clsCos);
    $display("test port class done");
  endtask
  task automatic t_mac;
    apb(1'h1, `QCM_OFF_MACLO, 32'h12345678);
    apb(1'h1, `QCM_OFF_MACCMD, 32'h00049ABC);
    frmMac <= 48'h9ABC12345678;
    frm(1'h1, 3'h0, 12'h001, 5'h02);
    chk("clsCos", 32'h4, clsCos);
    @(posedge sys_clk);
    frmMac <= 48'h9ABC12345679;
    frm(1'h1, 3'h0, 12'h001, 5'h02);
    chk("clsCos", 32'h2, clsCos);
    $display("test mac table done");
  endtask
  // load the egress model, then judge the grant order
  task automatic t_sched(input logic strict, input logic [15:0] cnt);
    logic seenLow;
    seenLow = 1'h0;
    apb(1'h1, `QCM_OFF_CTRL, {31'h0, strict});
    @(posedge sys_clk);
    loadCnt <= cnt;
    loadEn <= 1'h1;
    @(posedge sys_clk);
    loadEn <= 1'h0;
    for (int i = 3; i >= 0; i--) begin
      #1;
      if (strict) chk("grantQueue", i, grantQueue);
      if (i > 1 && grantQueue === 2'h0) seenLow = 1'h1;
      @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
    if (!strict) chk("wrrTurn", 32'h1, seenLow);
    chk("drained", 32'h0, queueReq);
    $display("test scheduler done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // watchdog: the whole sequence needs about 135 cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    print_verdict;
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'h1;
    t_prio;
    t_vlan;
    t_port;
    t_mac;
    t_sched(1'h1, 16'h1111);
    t_sched(1'h0, 16'h3003);
    print_verdict;
  end
endmodule // qcm_mapper_test
`default_nettype wire
